// ---- logic/bir_pkg.sv ----
// Package: register map, field positions, reset values and timing for the interrupt router.
package bir_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [5:0] BIR_OFF_CTRL = 6'h00;
  localparam logic [5:0] BIR_OFF_ELSEL = 6'h04;
  localparam logic [5:0] BIR_OFF_ROUTE = 6'h08;
  localparam logic [5:0] BIR_OFF_MASK = 6'h0c;
  localparam logic [5:0] BIR_OFF_STATUS = 6'h10;
  localparam logic [5:0] BIR_OFF_EOI = 6'h14;
  localparam logic [5:0] BIR_OFF_VMEICS = 6'h18;
  localparam logic [5:0] BIR_OFF_SERACK = 6'h1c;
  localparam logic [5:0] BIR_OFF_VMEACK = 6'h20;
  localparam logic [5:0] BIR_OFF_VECBASE = 6'h24;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int BIR_CTRL_NMI_EN = 0;
  localparam int BIR_CTRL_MCK_PAR_EN = 1;
  localparam int BIR_CTRL_ABORT_EN = 2;
  localparam int BIR_CTRL_KBD_INT = 4;
  localparam logic [31:0] BIR_CTRL_RST = 32'h0000_0010;

  // ----------------------------------------------------------------
  // VME interrupt control/status fields
  // ----------------------------------------------------------------
  localparam int BIR_ICS_LVL_LSB = 0;
  localparam int BIR_ICS_IEN = 3;

  // ----------------------------------------------------------------
  // Line layout
  // ----------------------------------------------------------------
  localparam int BIR_NIRQ = 16;
  localparam logic [15:0] BIR_ELSEL_RST = 16'h0000;
  // Lines 0, 1, 2, 8 and 13 stay edge mode.
  localparam logic [15:0] BIR_ELSEL_FIXED = 16'h2107;
  // Lines that may receive a routed PCI interrupt.
  localparam logic [15:0] BIR_ROUTE_OK = 16'hdef8;
  // Lines whose pin is active low (8, 9, 10, 11, 14, 15).
  localparam logic [15:0] BIR_ACT_LOW = 16'hcf00;
  localparam logic [3:0] BIR_ROUTE_OFF = 4'h0;
  localparam logic [31:0] BIR_ROUTE_RST = 32'h0000_0000;
  localparam logic [7:0] BIR_VECBASE_RST = 8'h08;
  localparam logic [7:0] BIR_NO_VECTOR = 8'hff;

  // ----------------------------------------------------------------
  // Timer counter 0 period
  // ----------------------------------------------------------------
  localparam int BIR_CLK_MHZ = 100;
  localparam int BIR_TICK_US = 40;
  localparam int BIR_TICK_CYC = BIR_TICK_US * BIR_CLK_MHZ;

endpackage : bir_pkg

// ---- logic/bir_sync.sv ----
// Two flip-flop synchroniser for one asynchronous level.
`timescale 1ns/100ps
`default_nettype none
module bir_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Level
  input wire logic d_i,
  output logic q_o
);
  typedef struct packed {
    logic s1;
    logic s2;
  } bir_sync_type;

  bir_sync_type st_ff;
  bir_sync_type nxt_st;

  always_comb begin
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.s2;
endmodule : bir_sync
`default_nettype wire

// ---- logic/bir_line.sv ----
// One request line: edge or level capture with pending flag and end-of-interrupt clear.
`timescale 1ns/100ps
`default_nettype none
module bir_line (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Request and control
  input wire logic req_i,
  input wire logic level_i,
  input wire logic eoi_i,
  output logic pend_o
);
  typedef struct packed {
    logic last;
    logic pend;
  } bir_line_type;

  bir_line_type st_ff;
  bir_line_type nxt_st;

  always_comb begin
    nxt_st.last = req_i;
    nxt_st.pend = st_ff.pend;
    if (eoi_i) begin
      nxt_st.pend = 1'b0;
    end
    // [R22] Level re-evaluated
    if (level_i) begin
      nxt_st.pend = req_i;
    end else if (req_i && !st_ff.last) begin
      nxt_st.pend = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pend_o = st_ff.pend;
endmodule : bir_line
`default_nettype wire

// ---- logic/bir_top.sv ----
// Board interrupt router: cascaded controllers, PCI routing, error escalation, pseudo acks.
//
// Function
// [R1] Bus error low raises NMI when enabled.
// [R2] NMI high raises machine check request.
// [R3] Bus or parity error raises check when enabled.
// [R4] Fifteen requests, secondary cascaded into primary.
// [R5] Edge/level selectable except five fixed lines.
// [R6] Four route registers steer PCI lines.
// [R7] Several PCI lines may share one line.
// [R8] Software sets routed lines to level mode.
// [R9] All lines reset to edge mode.
// [R10] Priority 0,1, then 8-15, then 3-7.
// [R11] Line 8 and level lines active low; the code fixes lines 8-11, 14 and 15 active low whatever their mode.
// [R12] Line 0 comes from internal timer.
// [R13] Software clears keyboard select bit four.
// [R14] Counter and serial share line 9.
// [R15] Encoded VME level raises bridge interrupt.
// [R16] Handler reads level then matching ack.
// [R17] Byte read of serial ack returns vector.
// [R18] Abort switch raises line 8 when enabled.
// [R19] Graphics and mezzanine share PCI line 3.
// [R20] Bridge interrupt needs enable and nonzero level.
// [R21] Pending level bits mirror encoded lines.
// [R22] Level lines stay pending while held.
`timescale 1ns/100ps
`default_nettype none
module bir_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Error and machine check
  input wire logic serr_n_i,
  input wire logic perr_n_i,
  output logic nmi_o,
  output logic machine_check_request_n_o,
  // ISA request pins, index = line number (0, 1 and 2 unused)
  input wire logic [15:0] irq_pin_i,
  input wire logic kbd_ext_irq_i,
  // PCI interrupt lines, active low
  input wire logic [2:0] pci_irq_lines_n_i,
  input wire logic gfx_irq_n_i,
  input wire logic mezz_irq_n_i,
  // VME interface and abort
  input wire logic [2:0] encoded_level_lines_n_i,
  input wire logic abort_switch_n_i,
  output logic abort_to_counter_o,
  // Pseudo acknowledge vectors from peripherals
  input wire logic counter_irq_i,
  input wire logic [7:0] counter_vec_i,
  input wire logic [7:0] serial_vec_i,
  input wire logic [7:0] vme_vec_i,
  output logic [2:0] vme_ack_level_o,
  // Interrupt to processor
  output logic intr_o,
  output logic [7:0] intr_vec_o
);
  import bir_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] elsel;
    logic [31:0] route;
    logic [15:0] mask;
    logic bridge_irq_enable;
    logic [7:0] vecbase;
    logic [31:0] rdata;
    logic ack;
    logic [15:0] eoi;
    logic [12:0] tick;
    logic timer;
    logic nmi;
    logic [2:0] pending_level_field;
    logic [3:0] best;
    logic any;
  } bir_state_type;

  bir_state_type st_ff;
  bir_state_type nxt_st;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 28;
  // Each synchroniser resets to its pin's idle level, so no false edge follows reset.
  localparam logic [NSYNC-1:0] SYNC_IDLE = {BIR_ACT_LOW, 1'b0, 2'b11, 3'b111, 3'b111, 3'b111};
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  assign raw_in = {irq_pin_i, kbd_ext_irq_i, serr_n_i, perr_n_i,
                   pci_irq_lines_n_i, gfx_irq_n_i, mezz_irq_n_i,
                   abort_switch_n_i, encoded_level_lines_n_i};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      bir_sync #(.RST_VAL(SYNC_IDLE[gi])) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .d_i(raw_in[gi]),
        .q_o(syn[gi])
      );
    end
  endgenerate
  logic abort_n_s;

  logic [15:0] pin_s;
  logic kbd_s, serr_n_s, perr_n_s, gfx_n_s, mezz_n_s;
  logic [2:0] pci_n_s;
  logic [2:0] ipl_n_s;
  assign pin_s = syn[27:12];
  assign kbd_s = syn[11];
  assign serr_n_s = syn[10];
  assign perr_n_s = syn[9];
  assign pci_n_s = syn[8:6];
  assign gfx_n_s = syn[5];
  assign mezz_n_s = syn[4];
  assign ipl_n_s = syn[2:0];
  assign abort_n_s = syn[3];

  // The abort pin is inverted and passed, unsynchronised, to the counter device's port input.
  // [R18] Abort to counter
  assign abort_to_counter_o = !abort_switch_n_i;

  // ----------------------------------------------------------------
  // Request assembly
  // ----------------------------------------------------------------
  logic [3:0] pci_act;
  logic [2:0] pending_level_field_now;
  logic bridge_irq;
  logic [15:0] routed;
  logic [15:0] req;
  logic [15:0] pend;
  logic [15:0] level;
  logic [15:0] active;

  // [R19] Shared PCI line
  assign pci_act[3] = !gfx_n_s || !mezz_n_s;
  assign pending_level_field_now = ~ipl_n_s;
  // [R20] Bridge interrupt gate
  assign bridge_irq = st_ff.bridge_irq_enable && (st_ff.pending_level_field != 3'h0);
  // [R15] Bridge drives PCI 1
  assign pci_act[1] = !pci_n_s[1] || bridge_irq;
  assign pci_act[0] = !pci_n_s[0];
  assign pci_act[2] = !pci_n_s[2];

  always_comb begin
    routed = '0;
    // [R6] Route steering
    for (int p = 0; p < 4; p++) begin
      for (int l = 0; l < BIR_NIRQ; l++) begin
        // [R7] OR onto shared line
        if (BIR_ROUTE_OK[l] && st_ff.route[p*8 +: 4] == 4'(l) && pci_act[p]) begin
          routed[l] = 1'b1;
        end
      end
    end
  end

  // [R11] Pin polarity
  assign active = pin_s ^ BIR_ACT_LOW;

  always_comb begin
    req = active | routed;
    // [R12] Internal timer
    req[0] = st_ff.timer;
    // [R13] Keyboard source select
    req[1] = st_ff.ctrl[BIR_CTRL_KBD_INT] ? 1'b0 : kbd_s;
    // [R18] Abort on line 8
    req[8] = (st_ff.ctrl[BIR_CTRL_ABORT_EN] && !abort_n_s) || !pin_s[8];
    // [R14] Counter and serial shared
    req[9] = active[9] || counter_irq_i;
    req[2] = 1'b0;
    req[13] = active[13];
  end

  // [R5] Fixed lines forced edge
  assign level = st_ff.elsel & ~BIR_ELSEL_FIXED;

  // [R4] Fifteen request lines
  generate
    for (gi = 0; gi < BIR_NIRQ; gi++) begin : g_line
      bir_line u_line (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .req_i(req[gi] && gi != 2),
        .level_i(level[gi]),
        .eoi_i(st_ff.eoi[gi]),
        .pend_o(pend[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  localparam logic [3:0] PRIO [0:14] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc,
                                         4'hd, 4'he, 4'hf, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
  logic [15:0] eligible;
  logic [3:0] best;
  logic any;
  assign eligible = pend & ~st_ff.mask;

  always_comb begin
    best = 4'h0;
    any = 1'b0;
    // [R10] Cascade priority order
    for (int k = 14; k >= 0; k--) begin
      if (eligible[PRIO[k]]) begin
        best = PRIO[k];
        any = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus slave and next state
  // ----------------------------------------------------------------
  logic wr, rd;
  logic [31:0] wmask;
  assign wr = avs_write_i && !st_ff.ack;
  assign rd = avs_read_i && !st_ff.ack;
  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = (avs_read_i || avs_write_i) && !st_ff.ack;
    nxt_st.eoi = '0;
    nxt_st.pending_level_field = pending_level_field_now;
    nxt_st.best = best;
    nxt_st.any = any;
    nxt_st.timer = 1'b0;
    nxt_st.tick = st_ff.tick + 13'h1;
    if (st_ff.tick == 13'(BIR_TICK_CYC - 1)) begin
      nxt_st.tick = '0;
      nxt_st.timer = 1'b1;
    end
    // [R1] SERR to NMI
    nxt_st.nmi = st_ff.ctrl[BIR_CTRL_NMI_EN] && !serr_n_s;
    if (wr) begin
      unique case (avs_address_i)
        BIR_OFF_CTRL: nxt_st.ctrl = (st_ff.ctrl & ~wmask) | (avs_writedata_i & wmask);
        BIR_OFF_ELSEL: begin
          if (avs_byteenable_i[0]) nxt_st.elsel[7:0] = avs_writedata_i[7:0];
          if (avs_byteenable_i[1]) nxt_st.elsel[15:8] = avs_writedata_i[15:8];
        end
        BIR_OFF_ROUTE: nxt_st.route = (st_ff.route & ~wmask) | (avs_writedata_i & wmask);
        BIR_OFF_MASK: begin
          if (avs_byteenable_i[0]) nxt_st.mask[7:0] = avs_writedata_i[7:0];
          if (avs_byteenable_i[1]) nxt_st.mask[15:8] = avs_writedata_i[15:8];
        end
        BIR_OFF_EOI: nxt_st.eoi = avs_writedata_i[15:0];
        BIR_OFF_VMEICS: begin
          if (avs_byteenable_i[0]) nxt_st.bridge_irq_enable = avs_writedata_i[BIR_ICS_IEN];
        end
        BIR_OFF_VECBASE: begin
          if (avs_byteenable_i[0]) nxt_st.vecbase = avs_writedata_i[7:0];
        end
        default: ;
      endcase
    end
    nxt_st.rdata = '0;
    if (rd) begin
      unique case (avs_address_i)
        BIR_OFF_CTRL: nxt_st.rdata = st_ff.ctrl;
        BIR_OFF_ELSEL: nxt_st.rdata = {16'h0, level};
        BIR_OFF_ROUTE: nxt_st.rdata = st_ff.route;
        BIR_OFF_MASK: nxt_st.rdata = {16'h0, st_ff.mask};
        BIR_OFF_STATUS: nxt_st.rdata = {16'h0, pend};
        // [R21] Level mirror
        BIR_OFF_VMEICS: nxt_st.rdata = {28'h0, st_ff.bridge_irq_enable, st_ff.pending_level_field};
        // [R17] Serial ack vector
        BIR_OFF_SERACK: nxt_st.rdata = {24'h0, counter_irq_i ? counter_vec_i : serial_vec_i};
        BIR_OFF_VMEACK: nxt_st.rdata = {24'h0, vme_vec_i};
        BIR_OFF_VECBASE: nxt_st.rdata = {24'h0, st_ff.vecbase};
        default: nxt_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff.ctrl <= BIR_CTRL_RST;
      // [R9] Edge mode after reset
      st_ff.elsel <= BIR_ELSEL_RST;
      st_ff.route <= BIR_ROUTE_RST;
      st_ff.mask <= '0;
      st_ff.bridge_irq_enable <= 1'b0;
      st_ff.vecbase <= BIR_VECBASE_RST;
      st_ff.rdata <= '0;
      st_ff.ack <= 1'b0;
      st_ff.eoi <= '0;
      st_ff.tick <= '0;
      st_ff.timer <= 1'b0;
      st_ff.nmi <= 1'b0;
      st_ff.pending_level_field <= '0;
      st_ff.best <= '0;
      st_ff.any <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest_o = !st_ff.ack;
  assign avs_readdata_o = st_ff.rdata;
  assign nmi_o = st_ff.nmi;
  // [R2] NMI to machine check
  // [R3] Parity error check
  assign machine_check_request_n_o = !(st_ff.nmi ||
      (st_ff.ctrl[BIR_CTRL_MCK_PAR_EN] && (!serr_n_s || !perr_n_s)));
  assign vme_ack_level_o = st_ff.pending_level_field;
  assign intr_o = st_ff.any;
  assign intr_vec_o = st_ff.vecbase + {4'h0, st_ff.best};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  nmi_follows_serr_a: assert property (st_ff.ctrl[BIR_CTRL_NMI_EN] && !serr_n_s |=> nmi_o) // [R1]
    else $error("NMI not raised after bus error");
  mck_on_nmi_a: assert property (nmi_o |-> !machine_check_request_n_o) // [R2]
    else $error("NMI did not raise machine check");
  mck_on_perr_a: assert property (st_ff.ctrl[BIR_CTRL_MCK_PAR_EN] && !perr_n_s
      |-> !machine_check_request_n_o) // [R3]
    else $error("parity error did not raise machine check");
  fixed_edge_a: assert property ((level & BIR_ELSEL_FIXED) == 16'h0) // [R5]
    else $error("fixed line in level mode");
  timer_period_a: assert property ($rose(st_ff.timer) |=> !st_ff.timer [*8]) // [R12]
    else $error("timer tick too close");
  bridge_gate_a: assert property (!st_ff.bridge_irq_enable |-> !bridge_irq) // [R20]
    else $error("bridge interrupt without enable");
  level_mirror_a: assert property (st_ff.pending_level_field == $past(pending_level_field_now)) // [R21]
    else $error("pending level bits stale");
  level_hold_a: assert property (level[10] && req[10] |=> pend[10]) // [R22]
    else $error("level line not pending");
  top_prio_a: assert property (eligible[0] |=> st_ff.best == 4'h0) // [R10]
    else $error("line 0 not highest");
  bus_ack_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o) // bus handshake
    else $error("bus access not answered");

  cov_nmi_c: cover property ($rose(nmi_o));
  cov_bridge_c: cover property ($rose(bridge_irq));
  cov_intr_c: cover property ($rose(intr_o));
endmodule : bir_top
`default_nettype wire

// ---- testbench/bir_host_model.sv ----
// Host model: Avalon-MM master standing for the processor and its software.
`timescale 1ns/100ps
`default_nettype none
module bir_host_model (
  // Clock
  input wire logic clk_i,
  // Avalon-MM master
  output logic [5:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i
);
  initial begin
    avs_address_o = 6'h00;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0;
    avs_byteenable_o = 4'h0;
  end

  // Holds the request until waitrequest is sampled low, then releases it.
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_o <= a;
    avs_writedata_o <= d;
    avs_byteenable_o <= b;
    avs_write_o <= w;
    avs_read_o <= !w;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_i !== 1'b0 && n < 50);
    q = avs_readdata_i;
    ok = (avs_waitrequest_i === 1'b0);
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    // Idle data lines carry garbage so stale values are never relied upon.
    avs_writedata_o <= ~d;
  endtask : acc
endmodule : bir_host_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the board interrupt router.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import bir_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [5:0] adr;
  logic rd_s, wr_s, wreq, nmi, mcr_n, abt_cnt, intr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] be;
  logic ok;
  logic serr_n = 1'b1, perr_n = 1'b1, kbd = 1'b0, gfx_n = 1'b1, mezz_n = 1'b1;
  logic abt_n = 1'b1, cnt_irq = 1'b0;
  logic [15:0] pin = BIR_ACT_LOW;
  logic [2:0] pci_n = 3'h7, lvl_n = 3'h7, vack;
  logic [7:0] cvec = 8'h00, svec = 8'h00, vvec = 8'h00, ivec;
  logic [31:0] seed = 32'h436404cd;
  int errors = 0;
  int check_count = 0;

  initial forever #5 clk_i = ~clk_i;

  bir_host_model u_bir_host_model (.clk_i(clk_i), .avs_address_o(adr), .avs_read_o(rd_s),
    .avs_write_o(wr_s), .avs_writedata_o(wdat), .avs_byteenable_o(be),
    .avs_readdata_i(rdat), .avs_waitrequest_i(wreq));

  bir_top u_bir_top (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(adr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .serr_n_i(serr_n), .perr_n_i(perr_n), .nmi_o(nmi),
    .machine_check_request_n_o(mcr_n), .irq_pin_i(pin), .kbd_ext_irq_i(kbd),
    .pci_irq_lines_n_i(pci_n), .gfx_irq_n_i(gfx_n), .mezz_irq_n_i(mezz_n),
    .encoded_level_lines_n_i(lvl_n), .abort_switch_n_i(abt_n), .abort_to_counter_o(abt_cnt),
    .counter_irq_i(cnt_irq), .counter_vec_i(cvec), .serial_vec_i(svec), .vme_vec_i(vvec),
    .vme_ack_level_o(vack), .intr_o(intr), .intr_vec_o(ivec));

  function automatic logic [31:0] nxt_rand(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : nxt_rand

  task automatic end_sim();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    u_bir_host_model.acc(w, a, d, b, q, ok);
    if (ok !== 1'b1) begin
      errors++;
      $display("Error at %0t: bus access not answered", $time);
      end_sim();
    end
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rc(input logic [5:0] a, input logic [3:0] b, input logic [31:0] m,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0, b);
    chk(q & m, e);
  endtask : rc

  // Lines 0 (timer) and 2 (cascade) are left out of status comparisons.
  task automatic st(input logic [31:0] e);
    rc(BIR_OFF_STATUS, 4'hf, 32'hfffa, e);
  endtask : st

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic wait_err(input logic [1:0] e);
    for (int n = 0; n < 12 && {nmi, mcr_n} !== e; n++) @(posedge clk_i);
    chk({nmi, mcr_n}, e);
  endtask : wait_err

  initial begin
    repeat (100000) @(posedge clk_i);
    errors++;
    $display("Error at %0t: run timed out", $time);
    end_sim();
  end

  initial begin
    cyc(4);
    srst_i <= 1'b0;
    seed = nxt_rand(seed);
    {cvec, svec, vvec} <= seed[23:0];
    chk({nmi, mcr_n, intr}, 3'b010);
    rc(BIR_OFF_CTRL, 4'hf, 32'hffffffff, BIR_CTRL_RST);
    rc(BIR_OFF_ELSEL, 4'hf, 32'hffff, 32'h0);
    rc(BIR_OFF_ROUTE, 4'hf, 32'hffffffff, BIR_ROUTE_RST);
    rc(BIR_OFF_VECBASE, 4'hf, 32'hff, {24'h0, BIR_VECBASE_RST});
    wr(6'h3c, seed);
    rc(6'h3c, 4'hf, 32'hffffffff, 32'h0);
    repeat (6) begin
      seed = nxt_rand(seed);
      wr(BIR_OFF_ELSEL, seed);
      rc(BIR_OFF_ELSEL, 4'hf, 32'hffff, {16'h0, seed[15:0] & ~BIR_ELSEL_FIXED});
    end
    // Keyboard taken from the external pin from here on.
    wr(BIR_OFF_CTRL, 32'h1);
    serr_n <= 1'b0;
    wait_err(2'b10);
    serr_n <= 1'b1;
    wait_err(2'b01);
    wr(BIR_OFF_CTRL, 32'h2);
    perr_n <= 1'b0;
    wait_err(2'b00);
    perr_n <= 1'b1;
    wait_err(2'b01);
    serr_n <= 1'b0;
    wait_err(2'b00);
    serr_n <= 1'b1;
    wait_err(2'b01);
    wr(BIR_OFF_MASK, 32'h1);
    wr(BIR_OFF_VECBASE, 32'h40);
    wr(BIR_OFF_ELSEL, 32'h0200);
    wr(BIR_OFF_EOI, 32'hffff);
    pin[3] <= 1'b1;
    pin[12] <= 1'b1;
    kbd <= 1'b1;
    cnt_irq <= 1'b1;
    cyc(2);
    pin[3] <= 1'b0;
    pin[12] <= 1'b0;
    kbd <= 1'b0;
    cyc(8);
    st(32'h120a);
    chk({intr, ivec}, 9'h141);
    wr(BIR_OFF_EOI, 32'h2);
    cyc(3);
    chk(ivec, 8'h49);
    rc(BIR_OFF_SERACK, 4'h1, 32'hff, {24'h0, cvec});
    wr(BIR_OFF_EOI, 32'h200);
    cyc(3);
    st(32'h1208);
    cnt_irq <= 1'b0;
    wr(BIR_OFF_EOI, 32'h200);
    cyc(3);
    chk(ivec, 8'h4c);
    rc(BIR_OFF_SERACK, 4'h1, 32'hff, {24'h0, svec});
    wr(BIR_OFF_EOI, 32'h1000);
    cyc(3);
    chk(ivec, 8'h43);
    wr(BIR_OFF_EOI, 32'h8);
    cyc(3);
    chk(intr, 1'b0);
    wr(BIR_OFF_CTRL, 32'h4);
    abt_n <= 1'b0;
    cyc(1);
    chk(abt_cnt, 1'b1);
    cyc(7);
    st(32'h100);
    abt_n <= 1'b1;
    wr(BIR_OFF_EOI, 32'h100);
    pin[8] <= 1'b0;
    cyc(8);
    st(32'h100);
    pin[8] <= 1'b1;
    wr(BIR_OFF_EOI, 32'h100);
    cyc(3);
    st(32'h0);
    // Routed lines are put in level mode before routing.
    wr(BIR_OFF_ELSEL, 32'h8e00);
    wr(BIR_OFF_ROUTE, 32'h0f0b0a0a);
    for (int k = 0; k < 5; k++) begin
      {mezz_n, gfx_n, pci_n} <= ~(5'h1 << k);
      cyc(8);
      st(k < 2 ? 32'h400 : (k == 2 ? 32'h800 : 32'h8000));
      {mezz_n, gfx_n, pci_n} <= 5'h1f;
      cyc(5);
      wr(BIR_OFF_EOI, 32'hffff);
    end
    wr(BIR_OFF_ROUTE, 32'h0f0b0a02);
    pci_n[0] <= 1'b0;
    cyc(8);
    st(32'h0);
    pci_n[0] <= 1'b1;
    wr(BIR_OFF_ELSEL, 32'hffff);
    repeat (4) begin
      do seed = nxt_rand(seed); while (BIR_ROUTE_OK[seed[3:0]] !== 1'b1);
      wr(BIR_OFF_ROUTE, {28'h0, seed[3:0]});
      pci_n[0] <= 1'b0;
      cyc(8);
      st(32'h1 << seed[3:0]);
      pci_n[0] <= 1'b1;
      cyc(5);
      wr(BIR_OFF_EOI, 32'hffff);
    end
    wr(BIR_OFF_ROUTE, 32'h0b00);
    lvl_n <= 3'b010;
    cyc(6);
    rc(BIR_OFF_VMEICS, 4'h1, 32'hf, 32'h5);
    st(32'h0);
    wr(BIR_OFF_VMEICS, 32'h8);
    cyc(8);
    st(32'h800);
    chk(vack, 3'h5);
    rc(BIR_OFF_VMEACK, 4'h1, 32'hff, {24'h0, vvec});
    lvl_n <= 3'b111;
    cyc(6);
    rc(BIR_OFF_VMEICS, 4'h1, 32'hf, 32'h8);
    wr(BIR_OFF_EOI, 32'hffff);
    cyc(3);
    st(32'h0);
    q = 32'h0;
    for (int n = 0; n < 1600 && q[0] !== 1'b1; n++) bus(1'b0, BIR_OFF_STATUS, 32'h0, 4'hf);
    chk(q[0], 1'b1);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
